// >>> hdl/multiport_fifo_bus_port.sv
// Slave FIFO bus port serving eight transmit and eight receive port FIFOs.
`timescale 1ns/1ns
module multiport_fifo_bus_port
	import fifo_bus_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Configuration
	input wire logic [1:0] i_bus_mode,
	// Bus selects and port selects
	input wire logic i_txsel_n,
	input wire logic i_rxsel_n,
	input wire logic [PORT_W-1:0] i_fps,
	input wire logic [PORT_W-1:0] i_split_tx_fps,
	input wire logic i_split_tx_sop,
	input wire logic i_split_tx_eop,
	// Data and byte enable pins
	input wire logic [DATA_W-1:0] i_fdat,
	output logic [DATA_W-1:0] o_fdat,
	output logic [1:0] o_fdat_oe,
	input wire logic [BE_W-1:0] i_fbe_n,
	output logic [BE_W-1:0] o_fbe_n,
	output logic [1:0] o_fbe_oe,
	// Packet markers and receive failure
	input wire logic i_sop,
	output logic o_sop,
	output logic o_sop_oe,
	input wire logic i_eop,
	output logic o_eop,
	output logic o_eop_oe,
	output logic o_rxfail,
	output logic o_rxfail_oe,
	// FIFO status
	output logic [NUM_PORTS-1:0] o_txfifo_full,
	output logic [NUM_PORTS-1:0] o_rxfifo_avail,
	// MAC side transmit drain
	input wire logic i_mac_tx_pop,
	input wire logic [PORT_W-1:0] i_mac_tx_port,
	output logic o_mac_tx_valid,
	output fifo_entry_t o_mac_tx_entry,
	// MAC side receive fill
	input wire logic i_mac_rx_push,
	input wire logic [PORT_W-1:0] i_mac_rx_port,
	input fifo_entry_t i_mac_rx_entry
);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	pin_sample_t pin_raw;
	pin_sample_t meta_r;
	pin_sample_t pin_r;

	always_comb begin
		pin_raw.txsel_n = i_txsel_n;
		pin_raw.rxsel_n = i_rxsel_n;
		pin_raw.fps = i_fps;
		pin_raw.tx_fps = i_split_tx_fps;
		pin_raw.tx_sop = i_split_tx_sop;
		pin_raw.tx_eop = i_split_tx_eop;
		pin_raw.fdat = i_fdat;
		pin_raw.fbe_n = i_fbe_n;
		pin_raw.sop = i_sop;
		pin_raw.eop = i_eop;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_r <= PIN_IDLE;
			pin_r <= PIN_IDLE;
		end else begin
			meta_r <= pin_raw;
			pin_r <= meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Port FIFOs
	// ----------------------------------------------------------------
	fifo_link_if tx_link [NUM_PORTS] ();
	fifo_link_if rx_link [NUM_PORTS] ();

	logic [NUM_PORTS-1:0] tx_ready_a;
	logic [NUM_PORTS-1:0] tx_avail_a;
	logic [NUM_PORTS-1:0] rx_ready_a;
	logic [NUM_PORTS-1:0] rx_avail_a;
	fifo_entry_t tx_head_a [NUM_PORTS];
	fifo_entry_t rx_head_a [NUM_PORTS];
	fifo_entry_t tx_entry;
	logic tx_req;
	logic rx_req;
	logic [PORT_W-1:0] tx_port;
	logic [PORT_W-1:0] rx_port;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		word_fifo u_tx_fifo (
			.i_clock(i_clock),
			.i_resetn(i_resetn),
			.link(tx_link[p])
		);
		word_fifo u_rx_fifo (
			.i_clock(i_clock),
			.i_resetn(i_resetn),
			.link(rx_link[p])
		);
		assign tx_link[p].push_valid = tx_req && (tx_port == PORT_W'(p));
		assign tx_link[p].push_entry = tx_entry;
		assign tx_link[p].pop_ready = i_mac_tx_pop && (i_mac_tx_port == PORT_W'(p));
		assign rx_link[p].push_valid = i_mac_rx_push && (i_mac_rx_port == PORT_W'(p));
		assign rx_link[p].push_entry = i_mac_rx_entry;
		assign rx_link[p].pop_ready = rx_req && (rx_port == PORT_W'(p));
		assign tx_ready_a[p] = tx_link[p].push_ready;
		assign tx_avail_a[p] = tx_link[p].pop_valid;
		assign tx_head_a[p] = tx_link[p].pop_entry;
		assign rx_ready_a[p] = rx_link[p].push_ready;
		assign rx_avail_a[p] = rx_link[p].pop_valid;
		assign rx_head_a[p] = rx_link[p].pop_entry;
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// In full and narrow modes the data pins are shared, so a read takes the bus
	// and a simultaneous write is ignored; only split mode has separate lanes.
	logic split_mode;
	logic rx_hit;
	fifo_entry_t rx_head;

	always_comb begin
		split_mode = (i_bus_mode == MODE_SPLIT);
		rx_req = !pin_r.rxsel_n;
		tx_req = !pin_r.txsel_n && (split_mode || !rx_req);
		rx_port = pin_r.fps;
		tx_port = split_mode ? pin_r.tx_fps : pin_r.fps;
		rx_head = rx_head_a[rx_port];
		rx_hit = rx_req && rx_avail_a[rx_port];
		tx_entry.fail = 1'b0;
		tx_entry.data = '0;
		tx_entry.be = '0;
		tx_entry.sop = pin_r.sop;
		tx_entry.eop = pin_r.eop;
		unique case (i_bus_mode)
			MODE_FULL: begin
				tx_entry.data = pin_r.fdat;
				tx_entry.be = ~pin_r.fbe_n;
			end
			MODE_SPLIT: begin
				tx_entry.data[HALF_W-1:0] = pin_r.fdat[DATA_W-1:HALF_W];
				tx_entry.be[HALF_BE_W-1:0] = ~pin_r.fbe_n[BE_W-1:HALF_BE_W];
				tx_entry.sop = pin_r.tx_sop;
				tx_entry.eop = pin_r.tx_eop;
			end
			default: begin
				// Narrow mode; the upper lanes are pulled up and are not stored.
				tx_entry.data[HALF_W-1:0] = pin_r.fdat[HALF_W-1:0];
				tx_entry.be[HALF_BE_W-1:0] = ~pin_r.fbe_n[HALF_BE_W-1:0];
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] fdat_r;
	logic [DATA_W-1:0] fdat_nxt;
	logic [1:0] lane_oe_r;
	logic [1:0] lane_oe_nxt;
	logic [BE_W-1:0] fbe_n_r;
	logic [BE_W-1:0] fbe_n_nxt;
	logic sop_r;
	logic sop_nxt;
	logic eop_r;
	logic eop_nxt;
	logic rxfail_r;
	logic rxfail_nxt;
	logic ctl_oe_r;
	logic ctl_oe_nxt;

	always_comb begin
		fdat_nxt = '0;
		fbe_n_nxt = '1;
		sop_nxt = 1'b0;
		eop_nxt = 1'b0;
		rxfail_nxt = 1'b0;
		ctl_oe_nxt = rx_req;
		lane_oe_nxt = OE_NONE;
		if (rx_req) begin
			lane_oe_nxt = (i_bus_mode == MODE_FULL) ? OE_BOTH : OE_LOW;
		end
		if (rx_hit) begin
			sop_nxt = rx_head.sop;
			eop_nxt = rx_head.eop;
			rxfail_nxt = rx_head.fail;
			if (i_bus_mode == MODE_FULL) begin
				fdat_nxt = rx_head.data;
				fbe_n_nxt = ~rx_head.be;
			end else begin
				fdat_nxt[HALF_W-1:0] = rx_head.data[HALF_W-1:0];
				fbe_n_nxt[HALF_BE_W-1:0] = ~rx_head.be[HALF_BE_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			fdat_r <= '0;
			lane_oe_r <= OE_NONE;
			fbe_n_r <= '1;
			sop_r <= 1'b0;
			eop_r <= 1'b0;
			rxfail_r <= 1'b0;
			ctl_oe_r <= 1'b0;
		end else begin
			fdat_r <= fdat_nxt;
			lane_oe_r <= lane_oe_nxt;
			fbe_n_r <= fbe_n_nxt;
			sop_r <= sop_nxt;
			eop_r <= eop_nxt;
			rxfail_r <= rxfail_nxt;
			ctl_oe_r <= ctl_oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// MAC side and status
	// ----------------------------------------------------------------
	logic mac_tx_valid_r;
	logic mac_tx_valid_nxt;
	fifo_entry_t mac_tx_entry_r;
	fifo_entry_t mac_tx_entry_nxt;
	logic [NUM_PORTS-1:0] txfifo_full_r;
	logic [NUM_PORTS-1:0] rxfifo_avail_r;

	always_comb begin
		mac_tx_valid_nxt = i_mac_tx_pop && tx_avail_a[i_mac_tx_port];
		mac_tx_entry_nxt = mac_tx_valid_nxt ? tx_head_a[i_mac_tx_port] : mac_tx_entry_r;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			mac_tx_valid_r <= 1'b0;
			mac_tx_entry_r <= '0;
			txfifo_full_r <= '0;
			rxfifo_avail_r <= '0;
		end else begin
			mac_tx_valid_r <= mac_tx_valid_nxt;
			mac_tx_entry_r <= mac_tx_entry_nxt;
			txfifo_full_r <= ~tx_ready_a;
			rxfifo_avail_r <= rx_avail_a;
		end
	end

	assign o_fdat = fdat_r;
	assign o_fdat_oe = lane_oe_r;
	assign o_fbe_n = fbe_n_r;
	assign o_fbe_oe = lane_oe_r;
	assign o_sop = sop_r;
	assign o_sop_oe = ctl_oe_r;
	assign o_eop = eop_r;
	assign o_eop_oe = ctl_oe_r;
	assign o_rxfail = rxfail_r;
	assign o_rxfail_oe = ctl_oe_r;
	assign o_txfifo_full = txfifo_full_r;
	assign o_rxfifo_avail = rxfifo_avail_r;
	assign o_mac_tx_valid = mac_tx_valid_r;
	assign o_mac_tx_entry = mac_tx_entry_r;

	// Receive entries whose port FIFO is full are dropped; no receive full status is output to the MAC.
	logic unused_rx_ready;
	assign unused_rx_ready = &rx_ready_a;

endmodule : multiport_fifo_bus_port

// >>> hdl/fifo_bus_pkg.sv
// Shared constants and types for the multiport FIFO bus port.
package fifo_bus_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 8;
	localparam int PORT_W = 3;
	localparam int DATA_W = 64;
	localparam int HALF_W = 32;
	localparam int BE_W = 8;
	localparam int HALF_BE_W = 4;
	localparam int FIFO_BYTES = 256;
	localparam int FIFO_DEPTH = FIFO_BYTES / (DATA_W / 8);
	localparam int ADDR_W = $clog2(FIFO_DEPTH);
	localparam int PTR_W = ADDR_W + 1;
	localparam logic [PTR_W-1:0] FIFO_DEPTH_PTR = PTR_W'(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// Bus modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_NARROW = 2'h1;
	localparam logic [1:0] MODE_SPLIT = 2'h2;

	// Output enable codes for the two 32-bit halves of the data and byte enable pins.
	localparam logic [1:0] OE_NONE = 2'h0;
	localparam logic [1:0] OE_LOW = 2'h1;
	localparam logic [1:0] OE_BOTH = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0] be;
		logic sop;
		logic eop;
		logic fail;
	} fifo_entry_t;

	typedef struct packed {
		logic txsel_n;
		logic rxsel_n;
		logic [PORT_W-1:0] fps;
		logic [PORT_W-1:0] tx_fps;
		logic tx_sop;
		logic tx_eop;
		logic [DATA_W-1:0] fdat;
		logic [BE_W-1:0] fbe_n;
		logic sop;
		logic eop;
	} pin_sample_t;

	// Idle level of the bus pins: selects and byte enables deasserted (high).
	localparam pin_sample_t PIN_IDLE = '{txsel_n: 1'b1, rxsel_n: 1'b1, fps: '0, tx_fps: '0,
		tx_sop: 1'b0, tx_eop: 1'b0, fdat: '0, fbe_n: '1, sop: 1'b0, eop: 1'b0};

endpackage : fifo_bus_pkg

// >>> hdl/fifo_link_if.sv
// Push and pop handshake between a port FIFO and the bus port logic.
`timescale 1ns/1ns
interface fifo_link_if;
	import fifo_bus_pkg::*;
	logic push_valid;
	logic push_ready;
	fifo_entry_t push_entry;
	logic pop_valid;
	logic pop_ready;
	fifo_entry_t pop_entry;

	modport fifo (input push_valid, input push_entry, input pop_ready,
		output push_ready, output pop_valid, output pop_entry);
	modport user (output push_valid, output push_entry, output pop_ready,
		input push_ready, input pop_valid, input pop_entry);
endinterface : fifo_link_if

// >>> hdl/word_fifo.sv
// One per-port FIFO of 256 bytes held as 32 entries of 64 data bits plus byte enables and flags in flip-flops.
`timescale 1ns/1ns
module word_fifo
	import fifo_bus_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Link to the bus port
	fifo_link_if.fifo link
);

	fifo_entry_t mem_r [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] wr_ptr_nxt;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [PTR_W-1:0] rd_ptr_nxt;
	logic do_push;
	logic do_pop;

	// ----------------------------------------------------------------
	// Pointers
	// ----------------------------------------------------------------
	always_comb begin
		link.push_ready = (PTR_W'(wr_ptr_r - rd_ptr_r) != FIFO_DEPTH_PTR);
		link.pop_valid = (wr_ptr_r != rd_ptr_r);
		link.pop_entry = mem_r[rd_ptr_r[ADDR_W-1:0]];
		do_push = link.push_valid && link.push_ready;
		do_pop = link.pop_ready && link.pop_valid;
		wr_ptr_nxt = do_push ? PTR_W'(wr_ptr_r + 1'b1) : wr_ptr_r;
		rd_ptr_nxt = do_pop ? PTR_W'(rd_ptr_r + 1'b1) : rd_ptr_r;
	end

	// Reset empties the FIFO by clearing both pointers; stale entries are never read.
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (do_push) begin
			mem_r[wr_ptr_r[ADDR_W-1:0]] <= link.push_entry;
		end
	end

endmodule : word_fifo

// >>> verif/fifo_bus_port_properties.sv
// Concurrent checks on the pins of the FIFO bus port.
`timescale 1ns/1ns
module fifo_bus_port_properties
	import fifo_bus_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Watched inputs
	input wire logic [1:0] i_bus_mode,
	input wire logic i_rxsel_n,
	input wire logic i_mac_rx_push,
	input wire logic [PORT_W-1:0] i_mac_rx_port,
	// Watched outputs
	input wire logic [DATA_W-1:0] o_fdat,
	input wire logic [1:0] o_fdat_oe,
	input wire logic [1:0] o_fbe_oe,
	input wire logic o_sop_oe,
	input wire logic o_rxfail_oe,
	input wire logic o_mac_tx_valid,
	input wire logic [NUM_PORTS-1:0] o_rxfifo_avail
);
	// ----------------------------------------------------------------
	// Pin timing: two sync stages plus the output register
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	a_reset_quiet: assert property ($rose(i_resetn) |->
		o_fdat_oe == OE_NONE && o_rxfifo_avail == '0 && !o_mac_tx_valid) else $error("outputs active after reset");
	a_idle_no_drive: assert property (i_rxsel_n |-> ##3 (o_fdat_oe == OE_NONE && !o_rxfail_oe))
		else $error("pins driven without receive select");
	a_full_drive: assert property (!i_rxsel_n && i_bus_mode == MODE_FULL |-> ##3
		(o_fdat_oe == OE_BOTH && o_fbe_oe == OE_BOTH && o_sop_oe)) else $error("full read not driving all lanes");
	a_split_drive: assert property (!i_rxsel_n && i_bus_mode == MODE_SPLIT |-> ##3
		(o_fdat_oe == OE_LOW && o_fbe_oe == OE_LOW && o_rxfail_oe)) else $error("split read lane enables wrong");
	a_narrow_drive: assert property (!i_rxsel_n && i_bus_mode == MODE_NARROW |-> ##3
		(o_fdat_oe == OE_LOW && o_sop_oe)) else $error("narrow read lane enables wrong");
	a_upper_quiet: assert property (!i_rxsel_n && i_bus_mode != MODE_FULL |-> ##3
		o_fdat[DATA_W-1:HALF_W] == '0) else $error("upper lanes carry data outside full mode");
	a_pop_cause: assert property (($past(o_rxfifo_avail) & ~o_rxfifo_avail) != '0 |->
		!$past(i_rxsel_n, 2) || !$past(i_rxsel_n, 3) || !$past(i_rxsel_n, 4)) else $error("receive FIFO drained unread");
	a_push_avail: assert property (i_mac_rx_push |-> ##2 o_rxfifo_avail[$past(i_mac_rx_port, 2)])
		else $error("receive data not flagged available");
endmodule : fifo_bus_port_properties

bind multiport_fifo_bus_port fifo_bus_port_properties u_props (.i_clock(i_clock), .i_resetn(i_resetn),
	.i_bus_mode(i_bus_mode), .i_rxsel_n(i_rxsel_n), .i_mac_rx_push(i_mac_rx_push), .i_mac_rx_port(i_mac_rx_port),
	.o_fdat(o_fdat), .o_fdat_oe(o_fdat_oe), .o_fbe_oe(o_fbe_oe), .o_sop_oe(o_sop_oe), .o_rxfail_oe(o_rxfail_oe),
	.o_mac_tx_valid(o_mac_tx_valid), .o_rxfifo_avail(o_rxfifo_avail));

// >>> verif/fifo_bus_master_model.sv
// Behavioural bus master that drives the FIFO bus pins.
`timescale 1ns/1ns
module fifo_bus_master_model
	import fifo_bus_pkg::*;
(
	// Clock and mode
	input wire logic i_clock,
	input wire logic [1:0] i_bus_mode,
	// Bus pins
	output pin_sample_t o_pins
);
	initial o_pins = PIN_IDLE;

	// One word for one clock cycle; a released bus shows inverted data, except the narrow-mode upper lanes held high, so stale values never match.
	task automatic xfer(input logic tx, input logic rx, input logic [PORT_W-1:0] txp, input logic [PORT_W-1:0] rxp,
		input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be_n, input logic sop, input logic eop);
		@(negedge i_clock);
		o_pins.txsel_n = !tx;
		o_pins.rxsel_n = !rx;
		if (i_bus_mode == MODE_SPLIT) begin
			o_pins.fps = rxp;
			o_pins.tx_fps = txp;
			o_pins.fdat = {d[31:0], ~d[31:0]};
			o_pins.fbe_n = {be_n[3:0], 4'hf};
			o_pins.tx_sop = sop;
			o_pins.tx_eop = eop;
		end else begin
			o_pins.fps = tx ? txp : rxp;
			o_pins.fdat = (i_bus_mode == MODE_NARROW) ? {32'hffff_ffff, d[31:0]} : d;
			o_pins.fbe_n = (i_bus_mode == MODE_NARROW) ? {4'hf, be_n[3:0]} : be_n;
			o_pins.sop = sop;
			o_pins.eop = eop;
		end
		@(negedge i_clock);
		o_pins.txsel_n = 1'b1;
		o_pins.rxsel_n = 1'b1;
		o_pins.fdat = {(i_bus_mode == MODE_NARROW) ? 32'hffff_ffff : ~o_pins.fdat[63:32], ~o_pins.fdat[31:0]};
		o_pins.fbe_n = ~o_pins.fbe_n;
		o_pins.sop = 1'b0;
		o_pins.eop = 1'b0;
		o_pins.tx_sop = 1'b0;
		o_pins.tx_eop = 1'b0;
	endtask : xfer
endmodule : fifo_bus_master_model

// >>> verif/multiport_fifo_bus_port_tb.sv
// Self-checking testbench for the multiport FIFO bus port.
`timescale 1ns/1ns
module multiport_fifo_bus_port_tb import fifo_bus_pkg::*;;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic [1:0] i_bus_mode = MODE_FULL;
	pin_sample_t pins;
	logic [DATA_W-1:0] o_fdat;
	logic [BE_W-1:0] o_fbe_n;
	logic [1:0] o_fdat_oe, o_fbe_oe;
	logic o_sop, o_sop_oe, o_eop, o_eop_oe, o_rxfail, o_rxfail_oe, o_mac_tx_valid;
	logic [NUM_PORTS-1:0] o_txfifo_full, o_rxfifo_avail;
	logic i_mac_tx_pop = 1'b0;
	logic i_mac_rx_push = 1'b0;
	logic [PORT_W-1:0] i_mac_tx_port = '0;
	logic [PORT_W-1:0] i_mac_rx_port = '0;
	fifo_entry_t i_mac_rx_entry = '0;
	fifo_entry_t o_mac_tx_entry;
	int errors = 0;
	int checked = 0;
	logic [74:0] rx_pins;

	assign rx_pins = {o_fdat, o_fbe_n, o_sop, o_eop, o_rxfail};

	always #2 i_clock = ~i_clock;

	fifo_bus_master_model u_master (.i_clock(i_clock), .i_bus_mode(i_bus_mode), .o_pins(pins));

	multiport_fifo_bus_port u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_bus_mode(i_bus_mode),
		.i_txsel_n(pins.txsel_n), .i_rxsel_n(pins.rxsel_n), .i_fps(pins.fps), .i_split_tx_fps(pins.tx_fps),
		.i_split_tx_sop(pins.tx_sop), .i_split_tx_eop(pins.tx_eop), .i_fdat(pins.fdat), .o_fdat(o_fdat),
		.o_fdat_oe(o_fdat_oe), .i_fbe_n(pins.fbe_n), .o_fbe_n(o_fbe_n), .o_fbe_oe(o_fbe_oe), .i_sop(pins.sop),
		.o_sop(o_sop), .o_sop_oe(o_sop_oe), .i_eop(pins.eop), .o_eop(o_eop), .o_eop_oe(o_eop_oe),
		.o_rxfail(o_rxfail), .o_rxfail_oe(o_rxfail_oe), .o_txfifo_full(o_txfifo_full),
		.o_rxfifo_avail(o_rxfifo_avail), .i_mac_tx_pop(i_mac_tx_pop), .i_mac_tx_port(i_mac_tx_port),
		.o_mac_tx_valid(o_mac_tx_valid), .o_mac_tx_entry(o_mac_tx_entry), .i_mac_rx_push(i_mac_rx_push),
		.i_mac_rx_port(i_mac_rx_port), .i_mac_rx_entry(i_mac_rx_entry));

	// ----------------------------------------------------------------
	// Helpers and scenarios
	// ----------------------------------------------------------------
	task automatic cmp(input string what, input logic [74:0] exp, input logic [74:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clock);
	endtask : wait_n

	task automatic pop(input logic [PORT_W-1:0] p);
		@(negedge i_clock);
		i_mac_tx_pop = 1'b1;
		i_mac_tx_port = p;
		@(negedge i_clock);
		i_mac_tx_pop = 1'b0;
	endtask : pop

	task automatic push(input logic [PORT_W-1:0] p, input fifo_entry_t e);
		@(negedge i_clock);
		i_mac_rx_push = 1'b1;
		i_mac_rx_port = p;
		i_mac_rx_entry = e;
		@(negedge i_clock);
		i_mac_rx_push = 1'b0;
		wait_n(1);
	endtask : push

	task automatic full_tx;
		u_master.xfer(1'b1, 1'b0, 3'h3, 3'h0, 64'hfedc_ba98_7654_3210, 8'h00, 1'b1, 1'b0);
		wait_n(2);
		pop(3'h3);
		cmp("tx_valid", 1'b1, o_mac_tx_valid);
		cmp("tx_full_word", {64'hfedc_ba98_7654_3210, 8'hff, 3'b100}, o_mac_tx_entry);
		u_master.xfer(1'b0, 1'b0, 3'h3, 3'h0, 64'h1234_5678_9abc_def0, 8'h00, 1'b1, 1'b0);
		wait_n(2);
		pop(3'h3);
		cmp("tx_unselected", 1'b0, o_mac_tx_valid);
	endtask : full_tx

	// Fills one transmit FIFO to the brim, offers one word too many, then drains it in order.
	task automatic tx_fill;
		for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
			u_master.xfer(1'b1, 1'b0, 3'h0, 3'h0, DATA_W'(i), 8'h00, 1'b0, 1'b0);
		end
		wait_n(3);
		cmp("tx_not_full", 8'h00, o_txfifo_full);
		u_master.xfer(1'b1, 1'b0, 3'h0, 3'h0, DATA_W'(FIFO_DEPTH - 1), 8'h00, 1'b0, 1'b0);
		wait_n(3);
		cmp("tx_full", 8'h01, o_txfifo_full);
		u_master.xfer(1'b1, 1'b0, 3'h0, 3'h0, 64'hffff_ffff_ffff_ffff, 8'h00, 1'b0, 1'b0);
		wait_n(2);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			pop(3'h0);
			cmp("tx_fill_order", {DATA_W'(i), 8'hff, 3'b000}, o_mac_tx_entry);
		end
		pop(3'h0);
		cmp("tx_full_drop", 1'b0, o_mac_tx_valid);
		cmp("tx_drained", 8'h00, o_txfifo_full);
	endtask : tx_fill

	task automatic full_rx;
		push(3'h5, {64'h0123_4567_89ab_cdef, 8'h3f, 3'b101});
		cmp("rx_avail", 8'h20, o_rxfifo_avail);
		u_master.xfer(1'b0, 1'b1, 3'h0, 3'h5, '0, '1, 1'b0, 1'b0);
		wait_n(2);
		cmp("rx_full_pins", {64'h0123_4567_89ab_cdef, 8'hc0, 3'b101}, rx_pins);
		cmp("rx_full_oe", 7'h7f, {o_fdat_oe, o_fbe_oe, o_sop_oe, o_eop_oe, o_rxfail_oe});
		wait_n(1);
		cmp("rx_drained", 8'h00, o_rxfifo_avail);
	endtask : full_rx

	task automatic narrow;
		i_bus_mode = MODE_NARROW;
		u_master.xfer(1'b1, 1'b0, 3'h1, 3'h0, 64'h0000_0000_dead_beef, 8'hf8, 1'b0, 1'b1);
		wait_n(2);
		pop(3'h1);
		cmp("tx_narrow_word", {32'h0, 32'hdead_beef, 8'h07, 3'b010}, o_mac_tx_entry);
		push(3'h2, {64'h1111_2222_3333_4444, 8'hff, 3'b010});
		u_master.xfer(1'b0, 1'b1, 3'h0, 3'h2, '0, '1, 1'b0, 1'b0);
		wait_n(2);
		cmp("rx_narrow_pins", {32'h0, 32'h3333_4444, 8'hf0, 3'b010}, rx_pins);
		cmp("rx_narrow_oe", 4'h5, {o_fdat_oe, o_fbe_oe});
		wait_n(2);
	endtask : narrow

	task automatic split;
		i_bus_mode = MODE_SPLIT;
		push(3'h6, {64'haaaa_bbbb_cccc_dddd, 8'h0f, 3'b110});
		u_master.xfer(1'b1, 1'b1, 3'h4, 3'h6, 64'h1357_9bdf, 8'hf0, 1'b1, 1'b0);
		wait_n(2);
		cmp("rx_split_pins", {32'h0, 32'hcccc_dddd, 8'hf0, 3'b110}, rx_pins);
		cmp("rx_split_oe", 4'h5, {o_fdat_oe, o_fbe_oe});
		pop(3'h4);
		cmp("tx_split_word", {32'h0, 32'h1357_9bdf, 8'h0f, 3'b100}, o_mac_tx_entry);
	endtask : split

	task automatic reset_flush;
		u_master.xfer(1'b1, 1'b0, 3'h7, 3'h0, 64'h2468_ace0, 8'hf0, 1'b1, 1'b1);
		push(3'h0, {64'h5555_6666_7777_8888, 8'hff, 3'b111});
		@(negedge i_clock);
		i_resetn = 1'b0;
		wait_n(2);
		i_resetn = 1'b1;
		cmp("avail_after_reset", 8'h00, o_rxfifo_avail);
		pop(3'h7);
		cmp("tx_after_reset", 1'b0, o_mac_tx_valid);
		cmp("rx_flushed", 8'h00, o_rxfifo_avail);
		cmp("tx_full_after_reset", 8'h00, o_txfifo_full);
	endtask : reset_flush

	task automatic conclude;
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	initial begin
		wait_n(2);
		i_resetn = 1'b1;
		full_tx;
		tx_fill;
		full_rx;
		narrow;
		split;
		reset_flush;
		conclude;
	end
endmodule : multiport_fifo_bus_port_tb
